/* core/brs_pkg.sv */
// package: constants for the boot rom shadow and port select glue block
package brs_pkg;
   // ***********************************************
   // clock and timing
   // ***********************************************
   localparam int unsigned CLK_HZ            = 100_000_000;
   localparam int unsigned BUS_CLK_HZ        = 2_000_000;
   localparam int unsigned BAUD_CLK_HZ       = 153_600;
   localparam int unsigned BAUD_MAX          = 9600;
   localparam int unsigned BAUD_OVERSAMPLE   = 16;
   localparam int unsigned RESET_HOLD_MS     = 470;
   localparam int unsigned RESET_MIN_MS      = 10;
   // half periods in system clocks, rounded down so no half period is too long
   localparam int unsigned BUS_CLK_HALF      = CLK_HZ / (2 * BUS_CLK_HZ);
   localparam int unsigned BAUD_CLK_HALF     = CLK_HZ / (2 * BAUD_CLK_HZ);
   localparam int unsigned CPU4_CLK_HALF     = BUS_CLK_HALF / 2;
   localparam int unsigned RESET_HOLD_CYC    = (CLK_HZ / 1000) * RESET_HOLD_MS;
   localparam int unsigned RESET_MIN_CYC     = (CLK_HZ / 1000) * RESET_MIN_MS;
   // ***********************************************
   // field layout
   // ***********************************************
   localparam int unsigned ROM_CMP_LSB       = 10;
   localparam int unsigned ROM_CMP_W         = 6;
   localparam int unsigned PORT_CMP_LSB      = 2;
   localparam int unsigned PORT_CMP_W        = 6;
   localparam int unsigned PORT_PAIR_BIT     = 1;
   localparam int unsigned CNT_W             = 26;
   localparam int unsigned DIV_W             = 10;
endpackage : brs_pkg

/* core/brs_glue.sv */
// module: boot rom window, power-on jump latch, serial port decode, strobes and reset stretch
// Functional notes
// - bus clock output runs at 2 MHz whatever cpu clock rate is chosen
// - bus reset low asserts cpu reset and power-on clear ~470 ms, and latch set if jump enabled
// - memory write strobe is high while memory request and write are both active, unless front panel present
// - front panel present suppresses our memory write strobe
// - rom window compares a10..a15 with switches, closed is 0, masked by rom size
// - address hit is window match during a memory read
// - reset sets the jump latch only when enable switch 8 is closed
// - rom select on memory read when latch set or address hit outside shadow mode, nothing else
// - rom select disables inbound bus data buffers
// - serial select, sense-switch disable low, run or ss low also disable buffers
// - shadow mode cuts hit path; latch set selects rom for every memory read
// - memory read with address hit clears latch unless reset stretch with jump enabled sets it; only reset sets it again
// - memory writes and io cycles never select rom
// - serial decoder compares a2..a7 with six switches, closed is 0
// - serial select needs io request, a1 low and port match
// - serial controller gets 16x baud clock, 153.6 kHz for 9600 baud
`timescale 1ns/1ps
module brs_glue #(
   parameter int unsigned RESET_HOLD_CYC = brs_pkg::RESET_HOLD_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [15:0] cpu_addr,
   input  wire logic        memory_request_n,
   input  wire logic        io_request_n,
   input  wire logic        cpu_rd_n,
   input  wire logic        cpu_wr_n,
   input  wire logic        bus_reset_n,
   input  wire logic        front_panel_present,
   input  wire logic        sense_switch_disable_n,
   input  wire logic        bus_run,
   input  wire logic        bus_ss,
   input  wire logic        reverse_channel_in,
   input  wire logic [5:0]  rom_addr_sw_closed,
   input  wire logic [5:0]  rom_size_mask,
   input  wire logic        jump_enable_sw_closed,
   input  wire logic        shadow_mode,
   input  wire logic [5:0]  port_addr_sw_closed,
   input  wire logic        cpu_clk_sel_4mhz,
   output logic             primary_bus_clock,
   output logic             cpu_clock,
   output logic             baud_clock,
   output logic             cpu_reset_n,
   output logic             power_on_clear_n,
   output logic             memory_write_strobe,
   output logic             rom_select_n,
   output logic             serial_port_select_n,
   output logic             data_in_disable,
   output logic             power_on_jump_latch,
   output logic             serial_busy
);
   // ***********************************************
   // input synchronisers: everything here arrives from pins
   // ***********************************************
   localparam int unsigned NSYNC = 16 + 12 + 18 + 1;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] s1_ff;
   logic [NSYNC-1:0] s2_ff;
   logic [NSYNC-1:0] nxt_s1;
   logic [NSYNC-1:0] nxt_s2;
   assign raw_in = {cpu_addr, memory_request_n, io_request_n, cpu_rd_n, cpu_wr_n, bus_reset_n,
                    front_panel_present, sense_switch_disable_n, bus_run, bus_ss, reverse_channel_in,
                    jump_enable_sw_closed, shadow_mode, rom_addr_sw_closed, rom_size_mask,
                    port_addr_sw_closed, cpu_clk_sel_4mhz};
   always_comb begin
      nxt_s1 = raw_in;
      nxt_s2 = s1_ff;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_ff <= '1;
         s2_ff <= '1;
      end else begin
         s1_ff <= nxt_s1;
         s2_ff <= nxt_s2;
      end
   end
   logic [15:0] a;
   logic        mreq_n;
   logic        ioreq_n;
   logic        rd_n;
   logic        wr_n;
   logic        breset_n;
   logic        fp;
   logic        sense_dis_n;
   logic        run;
   logic        ss;
   logic        busy_in;
   logic        jump_en;
   logic        shadow;
   logic        sel4;
   logic [5:0]  rom_sw;
   logic [5:0]  rom_mask;
   logic [5:0]  port_sw;
   // unpack in the same order the pins were packed above
   assign {a, mreq_n, ioreq_n, rd_n, wr_n, breset_n, fp, sense_dis_n, run, ss, busy_in,
           jump_en, shadow, rom_sw, rom_mask, port_sw, sel4} = s2_ff;

   // ***********************************************
   // reset stretch
   // ***********************************************
   // retriggers while bus reset is low, so hold never ends early
   logic [brs_pkg::CNT_W-1:0] rcnt_ff;
   logic [brs_pkg::CNT_W-1:0] nxt_rcnt;
   logic                      rst_act;
   assign rst_act = (rcnt_ff != '0);
   always_comb begin
      nxt_rcnt = rcnt_ff;
      if (!breset_n) nxt_rcnt = brs_pkg::CNT_W'(RESET_HOLD_CYC);
      else if (rcnt_ff != '0) nxt_rcnt = rcnt_ff - 1'b1;
   end

   // ***********************************************
   // decodes
   // ***********************************************
   logic mem_rd;
   logic mem_wr;
   logic win_match;
   logic addr_hit;
   logic port_match;
   logic rom_sel;
   logic port_sel;
   logic buf_dis;
   assign mem_rd     = !mreq_n && !rd_n;
   assign mem_wr     = !mreq_n && !wr_n;
   // closed switch reads as 0, so expected bit is the inverse of closed
   assign win_match  = (((a[brs_pkg::ROM_CMP_LSB +: brs_pkg::ROM_CMP_W] ^ ~rom_sw) & rom_mask) == '0);
   assign addr_hit   = win_match && mem_rd;
   assign port_match = (a[brs_pkg::PORT_CMP_LSB +: brs_pkg::PORT_CMP_W] == ~port_sw);
   assign port_sel   = !ioreq_n && !a[brs_pkg::PORT_PAIR_BIT] && port_match;
   // mem_rd excludes writes and io cycles
   assign rom_sel    = mem_rd && (power_on_jump_latch || (addr_hit && !shadow));
   assign buf_dis    = rom_sel || port_sel || !sense_dis_n || !run || !ss;

   // ***********************************************
   // power-on jump latch
   // ***********************************************
   logic nxt_jump;
   // set follows clear in program order, so reset wins a tie with a hit
   always_comb begin
      nxt_jump = power_on_jump_latch;
      if (addr_hit) nxt_jump = 1'b0;
      if (rst_act && jump_en) nxt_jump = 1'b1;
   end

   // ***********************************************
   // clock dividers
   // ***********************************************
   logic [brs_pkg::DIV_W-1:0] bdiv_ff;
   logic [brs_pkg::DIV_W-1:0] nxt_bdiv;
   logic [brs_pkg::DIV_W-1:0] cdiv_ff;
   logic [brs_pkg::DIV_W-1:0] nxt_cdiv;
   logic [brs_pkg::DIV_W-1:0] udiv_ff;
   logic [brs_pkg::DIV_W-1:0] nxt_udiv;
   logic                      nxt_bclk;
   logic                      nxt_cclk;
   logic                      nxt_uclk;
   logic [brs_pkg::DIV_W-1:0] chalf;
   assign chalf = sel4 ? brs_pkg::DIV_W'(brs_pkg::CPU4_CLK_HALF) : brs_pkg::DIV_W'(brs_pkg::BUS_CLK_HALF);
   always_comb begin
      nxt_bdiv = bdiv_ff + 1'b1;
      nxt_bclk = primary_bus_clock;
      if (bdiv_ff >= brs_pkg::DIV_W'(brs_pkg::BUS_CLK_HALF - 1)) begin
         nxt_bdiv = '0;
         nxt_bclk = !primary_bus_clock;
      end
      nxt_cdiv = cdiv_ff + 1'b1;
      nxt_cclk = cpu_clock;
      if (cdiv_ff >= chalf - 1'b1) begin
         nxt_cdiv = '0;
         nxt_cclk = !cpu_clock;
      end
      nxt_udiv = udiv_ff + 1'b1;
      nxt_uclk = baud_clock;
      if (udiv_ff >= brs_pkg::DIV_W'(brs_pkg::BAUD_CLK_HALF - 1)) begin
         nxt_udiv = '0;
         nxt_uclk = !baud_clock;
      end
   end

   // ***********************************************
   // output next values
   // ***********************************************
   // cpu reset and power-on clear share one stretch, so they never part
   logic nxt_cpu_reset_n;
   logic nxt_poc_n;
   logic nxt_wstrobe;
   logic nxt_rom_sel_n;
   logic nxt_port_sel_n;
   logic nxt_buf_dis;
   logic nxt_busy;
   always_comb begin
      nxt_cpu_reset_n = !(rst_act || !breset_n);
      nxt_poc_n       = !(rst_act || !breset_n);
      nxt_wstrobe     = mem_wr && !fp;
      nxt_rom_sel_n   = !rom_sel;
      nxt_port_sel_n  = !port_sel;
      nxt_buf_dis     = buf_dis;
      nxt_busy        = busy_in;
   end

   // ***********************************************
   // output registers
   // ***********************************************
   // outputs trail the cycle by the synchroniser and one flop; strobes span many clocks
   always_ff @(posedge clk) begin
      if (rst) begin
         rcnt_ff              <= '0;
         power_on_jump_latch  <= 1'b0;
         bdiv_ff              <= '0;
         cdiv_ff              <= '0;
         udiv_ff              <= '0;
         primary_bus_clock    <= 1'b0;
         cpu_clock            <= 1'b0;
         baud_clock           <= 1'b0;
         cpu_reset_n          <= 1'b0;
         power_on_clear_n     <= 1'b0;
         memory_write_strobe  <= 1'b0;
         rom_select_n         <= 1'b1;
         serial_port_select_n <= 1'b1;
         data_in_disable      <= 1'b1;
         serial_busy          <= 1'b0;
      end else begin
         rcnt_ff              <= nxt_rcnt;
         power_on_jump_latch  <= nxt_jump;
         bdiv_ff              <= nxt_bdiv;
         cdiv_ff              <= nxt_cdiv;
         udiv_ff              <= nxt_udiv;
         primary_bus_clock    <= nxt_bclk;
         cpu_clock            <= nxt_cclk;
         baud_clock           <= nxt_uclk;
         cpu_reset_n          <= nxt_cpu_reset_n;
         power_on_clear_n     <= nxt_poc_n;
         memory_write_strobe  <= nxt_wstrobe;
         rom_select_n         <= nxt_rom_sel_n;
         serial_port_select_n <= nxt_port_sel_n;
         data_in_disable      <= nxt_buf_dis;
         serial_busy          <= nxt_busy;
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   // every output follows its decode one clock later, hence the |=> forms
   a_wstrobe_gate: assert property (@(posedge clk) disable iff (rst)
      (mem_wr && !fp) |=> memory_write_strobe) else $error("write strobe missing");
   a_fp_suppress: assert property (@(posedge clk) disable iff (rst)
      fp |=> !memory_write_strobe) else $error("write strobe with front panel");
   a_rom_no_write: assert property (@(posedge clk) disable iff (rst)
      (!mem_rd) |=> rom_select_n) else $error("rom selected outside memory read");
   a_rom_by_latch: assert property (@(posedge clk) disable iff (rst)
      (mem_rd && power_on_jump_latch) |=> !rom_select_n) else $error("latch read missed rom");
   a_hit_selects: assert property (@(posedge clk) disable iff (rst)
      (addr_hit && !shadow) |=> !rom_select_n) else $error("window hit missed rom");
   a_shadow_cut: assert property (@(posedge clk) disable iff (rst)
      (shadow && !power_on_jump_latch) |=> rom_select_n) else $error("shadow hit selected rom");
   a_buf_on_rom: assert property (@(posedge clk) disable iff (rst)
      !rom_select_n |-> data_in_disable) else $error("buffers on during rom read");
   a_buf_on_port: assert property (@(posedge clk) disable iff (rst)
      (port_sel || !run || !ss || !sense_dis_n) |=> data_in_disable) else $error("buffers not disabled");
   a_buf_enabled: assert property (@(posedge clk) disable iff (rst)
      (!rom_sel && !port_sel && sense_dis_n && run && ss) |=> !data_in_disable) else $error("buffers off idle");
   a_hit_clears: assert property (@(posedge clk) disable iff (rst)
      (addr_hit && !(rst_act && jump_en)) |=> !power_on_jump_latch) else $error("latch not cleared");
   a_latch_no_set: assert property (@(posedge clk) disable iff (rst)
      !(rst_act && jump_en) |=> !$rose(power_on_jump_latch)) else $error("latch set without reset");
   a_reset_sets: assert property (@(posedge clk) disable iff (rst)
      (rst_act && jump_en) |=> power_on_jump_latch) else $error("reset did not set latch");
   a_reset_out: assert property (@(posedge clk) disable iff (rst)
      (!breset_n) |=> (!cpu_reset_n && !power_on_clear_n)) else $error("bus reset not passed on");
   a_stretch_load: assert property (@(posedge clk) disable iff (rst)
      (!breset_n) |=> (rcnt_ff == brs_pkg::CNT_W'(RESET_HOLD_CYC))) else $error("stretch not reloaded");
   a_stretch_hold: assert property (@(posedge clk) disable iff (rst)
      rst_act |=> !power_on_clear_n) else $error("clear released during stretch");
   a_reset_hold: assert property (@(posedge clk) disable iff (rst)
      $rose(breset_n) |=> !power_on_clear_n [*8]) else $error("reset hold too short");
   a_port_match: assert property (@(posedge clk) disable iff (rst)
      port_sel |=> !serial_port_select_n) else $error("port not selected");
   a_port_sel: assert property (@(posedge clk) disable iff (rst)
      (!ioreq_n && a[1]) |=> serial_port_select_n) else $error("port select with a1 high");
   a_port_needs_io: assert property (@(posedge clk) disable iff (rst)
      ioreq_n |=> serial_port_select_n) else $error("port select without io request");
   a_bus_clk_half: assert property (@(posedge clk) disable iff (rst)
      $rose(primary_bus_clock) |=> primary_bus_clock [*8]) else $error("bus clock half too short");
   a_bus_clk_low: assert property (@(posedge clk) disable iff (rst)
      $fell(primary_bus_clock) |=> !primary_bus_clock [*8]) else $error("bus clock low half too short");
   a_cpu_clk_half: assert property (@(posedge clk) disable iff (rst)
      $rose(cpu_clock) |=> cpu_clock [*8]) else $error("cpu clock half too short");
   a_baud_half: assert property (@(posedge clk) disable iff (rst)
      $rose(baud_clock) |=> baud_clock [*8]) else $error("baud clock half too short");
   a_busy_follow: assert property (@(posedge clk) disable iff (rst)
      busy_in |=> serial_busy) else $error("busy not passed on");
   c_rom_boot: cover property (@(posedge clk) disable iff (rst) mem_rd && power_on_jump_latch);
   c_shadow_boot: cover property (@(posedge clk) disable iff (rst) shadow && mem_rd && power_on_jump_latch);
   c_latch_clear: cover property (@(posedge clk) disable iff (rst) $fell(power_on_jump_latch));
   c_port_sel: cover property (@(posedge clk) disable iff (rst) port_sel);
   c_mem_write: cover property (@(posedge clk) disable iff (rst) memory_write_strobe);
endmodule : brs_glue

/* sim/brs_cpu_model.sv */
// cpu strobe and peripheral model driving the processor side of the glue block
`timescale 1ns/1ps
module brs_cpu_model (
   input  wire logic        clk,
   input  wire logic [1:0]  cmd,
   input  wire logic [15:0] addr,
   input  wire logic        busy,
   output logic [15:0]      cpu_addr,
   output logic             memory_request_n,
   output logic             io_request_n,
   output logic             cpu_rd_n,
   output logic             cpu_wr_n,
   output logic             reverse_channel_in
);
   // ***********************************************
   // strobes change on the falling edge only
   // ***********************************************
   initial begin
      cpu_addr = 16'h0000;
      {memory_request_n, io_request_n, cpu_rd_n, cpu_wr_n} = 4'hf;
      reverse_channel_in = 1'b0;
   end
   // cmd: 0 idle, 1 memory read, 2 memory write, 3 io read
   always @(negedge clk) begin
      memory_request_n <= !(cmd == 2'h1 || cmd == 2'h2);
      io_request_n <= (cmd != 2'h3);
      cpu_rd_n <= !(cmd == 2'h1 || cmd == 2'h3);
      cpu_wr_n <= (cmd != 2'h2);
      // released bus shows the inverse, never a stale copy
      cpu_addr <= (cmd == 2'h0) ? ~cpu_addr : addr;
      reverse_channel_in <= busy;
   end
endmodule : brs_cpu_model

/* sim/testbench.sv */
// self-checking bench for the boot rom shadow and port select glue block
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, rst = 1'b1, bus_reset_n = 1'b1, front_panel_present = 1'b0, busy = 1'b0;
   logic sense_switch_disable_n = 1'b1, bus_run = 1'b1, bus_ss = 1'b1, jump_enable_sw_closed = 1'b0;
   logic shadow_mode = 1'b0, cpu_clk_sel_4mhz = 1'b0;
   logic [5:0] rom_addr_sw_closed = 6'h2a, rom_size_mask = 6'h3f, port_addr_sw_closed = 6'h07;
   logic [1:0] cmd = 2'h0;
   logic [15:0] addr = 16'h0000, cpu_addr;
   logic memory_request_n, io_request_n, cpu_rd_n, cpu_wr_n, reverse_channel_in;
   logic primary_bus_clock, cpu_clock, baud_clock, cpu_reset_n, power_on_clear_n, memory_write_strobe;
   logic rom_select_n, serial_port_select_n, data_in_disable, power_on_jump_latch, serial_busy;
   int error_cnt = 0, checks_done = 0, n, i;
   // ***********************************************
   // clock, partner and design
   // ***********************************************
   initial begin
      forever #5 clk = ~clk;
   end
   brs_cpu_model i_cpu (.clk, .cmd, .addr, .busy, .cpu_addr, .memory_request_n, .io_request_n,
      .cpu_rd_n, .cpu_wr_n, .reverse_channel_in);
   // short stretch keeps the run small; expectations below assume 20
   brs_glue #(.RESET_HOLD_CYC(20)) i_dut (.clk, .rst, .cpu_addr, .memory_request_n, .io_request_n,
      .cpu_rd_n, .cpu_wr_n, .bus_reset_n, .front_panel_present, .sense_switch_disable_n, .bus_run,
      .bus_ss, .reverse_channel_in, .rom_addr_sw_closed, .rom_size_mask, .jump_enable_sw_closed,
      .shadow_mode, .port_addr_sw_closed, .cpu_clk_sel_4mhz, .primary_bus_clock, .cpu_clock,
      .baud_clock, .cpu_reset_n, .power_on_clear_n, .memory_write_strobe, .rom_select_n,
      .serial_port_select_n, .data_in_disable, .power_on_jump_latch, .serial_busy);
   // ***********************************************
   // tasks
   // ***********************************************
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_n(input int got, input int exp);
      checks_done++;
      if (got != exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_n
   // hold each cycle state long enough for the two-flop input path
   task automatic cyc(input logic [1:0] k, input logic [15:0] a);
      @(negedge clk);
      cmd = k;
      addr = a;
      repeat (4) @(negedge clk);
   endtask : cyc
   // period of one generated clock, in system clocks
   task automatic period(input int which, output int p);
      logic prev, cur;
      int k, rises;
      prev = 1'b1;
      rises = 0;
      p = 0;
      for (k = 0; k < 3000 && rises < 2; k++) begin
         @(posedge clk);
         #1;
         cur = (which == 0) ? primary_bus_clock : (which == 1) ? cpu_clock : baud_clock;
         if (cur && !prev) rises++;
         if (rises == 1) p++;
         prev = cur;
      end
      if (rises < 2) begin
         chk_n(rises, 2);
         finish_test();
      end
   endtask : period
   task automatic breset(input logic exp_latch);
      @(negedge clk);
      bus_reset_n = 1'b0;
      repeat (6) @(negedge clk);
      chk(cpu_reset_n, 1'b0);
      chk(power_on_clear_n, 1'b0);
      chk(power_on_jump_latch, exp_latch);
      bus_reset_n = 1'b1;
      repeat (10) @(negedge clk);
      chk(power_on_clear_n, 1'b0);
      repeat (20) @(negedge clk);
      chk(cpu_reset_n, 1'b1);
   endtask : breset
   // ***********************************************
   // main sequence
   // ***********************************************
   initial begin
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      chk(power_on_jump_latch, 1'b0);
      period(0, n); chk_n(n, 50);
      @(negedge clk);
      cpu_clk_sel_4mhz = 1'b1;
      repeat (4) @(negedge clk);
      period(1, n); chk_n(n, int'(2 * brs_pkg::CPU4_CLK_HALF));
      period(0, n); chk_n(n, 50);
      period(2, n); chk_n(n, 650);
      cyc(2'h2, 16'h1234); chk(memory_write_strobe, 1'b1);
      front_panel_present = 1'b1;
      cyc(2'h2, 16'h1234); chk(memory_write_strobe, 1'b0);
      front_panel_present = 1'b0;
      cyc(2'h1, 16'h5400); chk(rom_select_n, 1'b0); chk(data_in_disable, 1'b1);
      cyc(2'h1, 16'h5000); chk(rom_select_n, 1'b1); chk(data_in_disable, 1'b0);
      rom_size_mask = 6'h3e;
      cyc(2'h1, 16'h5000); chk(rom_select_n, 1'b0);
      rom_size_mask = 6'h3f;
      cyc(2'h2, 16'h5400); chk(rom_select_n, 1'b1);
      cyc(2'h3, 16'h5400); chk(rom_select_n, 1'b1);
      cyc(2'h3, 16'h00e0); chk(serial_port_select_n, 1'b0); chk(data_in_disable, 1'b1);
      cyc(2'h3, 16'h00e2); chk(serial_port_select_n, 1'b1);
      cyc(2'h3, 16'h00e4); chk(serial_port_select_n, 1'b1);
      cyc(2'h1, 16'h00e0); chk(serial_port_select_n, 1'b1);
      for (i = 0; i < 3; i++) begin
         {sense_switch_disable_n, bus_run, bus_ss} = ~(3'h1 << i);
         cyc(2'h1, 16'h1000); chk(data_in_disable, 1'b1);
      end
      {sense_switch_disable_n, bus_run, bus_ss} = 3'h7;
      busy = 1'b1;
      cyc(2'h0, 16'h0000); chk(serial_busy, 1'b1);
      breset(1'b0);
      jump_enable_sw_closed = 1'b1;
      cyc(2'h1, 16'h5400);
      breset(1'b1);
      chk(power_on_jump_latch, 1'b0);
      cyc(2'h0, 16'h0000);
      breset(1'b1);
      cyc(2'h1, 16'h1000); chk(rom_select_n, 1'b0);
      cyc(2'h2, 16'h1000); chk(rom_select_n, 1'b1);
      shadow_mode = 1'b1;
      cyc(2'h1, 16'h0000); chk(rom_select_n, 1'b0);
      cyc(2'h1, 16'h5400); chk(power_on_jump_latch, 1'b0); chk(rom_select_n, 1'b1);
      cyc(2'h1, 16'h0000); chk(rom_select_n, 1'b1);
      finish_test();
   end
endmodule : testbench
